// ---- core/lleu_map.svh ----
// Register offsets, field positions, reset values and status codes of the data unit
`ifndef LLEU_MAP_SVH
`define LLEU_MAP_SVH

`define LLEU_A_CTRL 8'h00
`define LLEU_A_OPA 8'h04
`define LLEU_A_OPB 8'h08
`define LLEU_A_CMD 8'h0c
`define LLEU_A_RES_LO 8'h10
`define LLEU_A_RES_HI 8'h14
`define LLEU_A_STATUS 8'h18
`define LLEU_A_CODE 8'h1c
`define LLEU_A_PTR 8'h20
`define LLEU_A_AXLO 8'h24
`define LLEU_A_AXHI 8'h28
`define LLEU_A_AXIS 8'h40
`define LLEU_A_AXIS_END 8'h5c

`define LLEU_C_ENABLE 0
`define LLEU_C_RUN 1
`define LLEU_C_ERRCLR 2
`define LLEU_C_SWEEP_END 4

`define LLEU_F_OP 3:0
`define LLEU_F_IDX 11:4
`define LLEU_F_SWM1 17:12
`define LLEU_F_SSGN 18
`define LLEU_F_DWM1 24:19
`define LLEU_F_DEST 27:25
`define LLEU_F_DWIDE 28
`define LLEU_F_TSZ 30:29

`define LLEU_AXLO_RST 32'h00000000
`define LLEU_AXHI_RST 32'h0000ffff

`define LLEU_GP_COUNT 9'd255
`define LLEU_GP_DEPTH 256
`define LLEU_WIDE_COUNT 8
`define LLEU_TBL_DEPTH 8192

`define LLEU_CODE_HALT 16'h0091
`define LLEU_CODE_DIV0 16'h0093
`define LLEU_CODE_DIVOVF 16'h0094
`define LLEU_CODE_ADDOVF 16'h0095
`define LLEU_CODE_ABSOVF 16'h0096
`define LLEU_CODE_AXWARN 16'h00a0

`endif

// ---- core/lleu_pkg.sv ----
// Types shared by the data unit files
package lleu_pkg;
  typedef enum logic [1:0] {
    LLEU_S_IDLE = 2'b00,
    LLEU_S_GPRD = 2'b01,
    LLEU_S_TBL = 2'b10
  } lleu_state_t;

  typedef enum logic [3:0] {
    LLEU_OP_ADD = 4'h0,
    LLEU_OP_SUB = 4'h1,
    LLEU_OP_ABS = 4'h2,
    LLEU_OP_AND = 4'h3,
    LLEU_OP_OR = 4'h4,
    LLEU_OP_XOR = 4'h5,
    LLEU_OP_MUL = 4'h6,
    LLEU_OP_DIV = 4'h7,
    LLEU_OP_MOD = 4'h8,
    LLEU_OP_MOVE = 4'h9,
    LLEU_OP_LDGP = 4'ha,
    LLEU_OP_TBLRD = 4'hb,
    LLEU_OP_TBLWR = 4'hc,
    LLEU_OP_SETPTR = 4'hd
  } lleu_op_t;

  typedef enum logic [2:0] {
    LLEU_D_NONE = 3'h0,
    LLEU_D_GP = 3'h1,
    LLEU_D_WIDE = 3'h2,
    LLEU_D_OVF = 3'h3,
    LLEU_D_HALT = 3'h4,
    LLEU_D_AXIS = 3'h5
  } lleu_dest_t;
endpackage

// ---- core/lleu_ram.sv ----
// Simple dual-port memory with registered read data
module lleu_ram #(
  parameter int W = 8,
  parameter int D = 8192,
  parameter int AW = 13
) (
  input wire logic pclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata_q
);
  logic [W-1:0] mem [D];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // No reset: contents survive a start of execution
  always_ff @(posedge pclk) begin
    rdata_q <= mem[raddr];
  end
endmodule

// ---- core/lleu_core.sv ----
// Logic engine data unit: typed operands, signed arithmetic, system flags, data table
`include "lleu_map.svh"

module lleu_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic fast_stop,
  output logic [15:0] status_code
);
  import lleu_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lleu_ext(input logic [31:0] v, input logic [5:0] wm1,
                                           input logic sgn);
    logic [31:0] m;
    logic [31:0] r;
    m = 32'hffffffff >> (5'd31 - wm1[4:0]);
    r = v & m;
    if (wm1 >= 6'd31) begin
      r = v;
    end else if (sgn && (wm1 != 6'd0) && v[wm1[4:0]]) begin
      r = r | ~m;
    end
    return r;
  endfunction

  function automatic logic [63:0] lleu_trunc(input logic [63:0] v, input logic [5:0] wm1);
    logic [63:0] m;
    m = 64'hffffffffffffffff >> (6'd63 - wm1);
    return v & m;
  endfunction

  function automatic logic [2:0] lleu_bytes(input logic [1:0] tsz);
    logic [2:0] n;
    case (tsz)
      2'h0: n = 3'd1;
      2'h1: n = 3'd2;
      default: n = 3'd4;
    endcase
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  logic enable_q, run_q, errclr_q, running_q;
  logic [31:0] opa_q, opb_q, cmd_q, axlo_q, axhi_q;
  logic [63:0] res_q;
  logic go_q, first_q, ovf_q, ovf_abs_q, halted_q, reject_q;
  logic [15:0] code_q;
  logic [12:0] ptr_q;
  logic [63:0] wide_q [`LLEU_WIDE_COUNT];
  logic [31:0] axis_q [8];
  lleu_state_t state_q;
  logic [2:0] tleft_q;
  logic [1:0] tgot_q;
  logic rdpend_q;
  logic [31:0] tasm_q;

  logic wr, rd, start, errclr_tgl, sweep_end, exec_ok, busy;
  logic [3:0] op;
  logic [7:0] idx;
  logic [5:0] swm1, dwm1;
  logic ssgn, dwide;
  lleu_dest_t dest;
  logic [2:0] tbytes;
  logic [31:0] a, b;
  logic [32:0] sum33, dif33;
  logic [63:0] prod, dvd, dvs, quo, rem, imm;
  logic add_ovf, sub_ovf, abs_ovf, div0, divovf, rejected, is_imm;
  logic commit;
  logic [63:0] cval, stv;
  logic issue, tbl_done;
  logic [1:0] bsel;
  logic [7:0] tbl_rdata;
  logic [31:0] gp_rdata;
  logic [31:0] tbl_word;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign busy = go_q || (state_q != LLEU_S_IDLE);
  assign start = enable_q && run_q && !running_q;
  assign errclr_tgl = wr && (paddr == `LLEU_A_CTRL) && (pwdata[`LLEU_C_ERRCLR] != errclr_q);
  assign sweep_end = wr && (paddr == `LLEU_A_CTRL) && pwdata[`LLEU_C_SWEEP_END];
  assign exec_ok = running_q && !halted_q;
  assign fast_stop = halted_q;
  assign status_code = code_q;

  assign op = cmd_q[`LLEU_F_OP];
  assign idx = cmd_q[`LLEU_F_IDX];
  assign swm1 = cmd_q[`LLEU_F_SWM1];
  assign ssgn = cmd_q[`LLEU_F_SSGN];
  assign dwm1 = cmd_q[`LLEU_F_DWM1];
  assign dest = lleu_dest_t'(cmd_q[`LLEU_F_DEST]);
  assign dwide = cmd_q[`LLEU_F_DWIDE];
  assign tbytes = lleu_bytes(cmd_q[`LLEU_F_TSZ]);

  ////////////////////////////////////////////////////////////////////////////////
  // Host control bits and operand registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= 1'b0;
      run_q <= 1'b0;
      errclr_q <= 1'b0;
      running_q <= 1'b0;
    end else begin
      running_q <= enable_q && run_q;
      if (wr && (paddr == `LLEU_A_CTRL)) begin
        enable_q <= pwdata[`LLEU_C_ENABLE];
        run_q <= pwdata[`LLEU_C_RUN];
        errclr_q <= pwdata[`LLEU_C_ERRCLR];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opa_q <= 32'h00000000;
      opb_q <= 32'h00000000;
      axlo_q <= `LLEU_AXLO_RST;
      axhi_q <= `LLEU_AXHI_RST;
    end else if (wr) begin
      if (paddr == `LLEU_A_OPA) opa_q <= pwdata;
      if (paddr == `LLEU_A_OPB) opb_q <= pwdata;
      if (paddr == `LLEU_A_AXLO) axlo_q <= pwdata;
      if (paddr == `LLEU_A_AXHI) axhi_q <= pwdata;
    end
  end

  // A command written while busy is dropped; software polls the busy bit first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= 32'h00000000;
      go_q <= 1'b0;
    end else begin
      go_q <= wr && (paddr == `LLEU_A_CMD) && !busy;
      if (wr && (paddr == `LLEU_A_CMD) && !busy) cmd_q <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Operand loading and arithmetic
  assign a = lleu_ext(opa_q, swm1, ssgn);
  assign b = opb_q;
  assign sum33 = {a[31], a} + {b[31], b};
  assign dif33 = {a[31], a} - {b[31], b};
  assign add_ovf = sum33[32] ^ sum33[31];
  assign sub_ovf = dif33[32] ^ dif33[31];
  assign abs_ovf = (a == 32'h80000000);
  assign prod = $signed({{32{a[31]}}, a}) * $signed({{32{b[31]}}, b});
  assign dvd = dwide ? wide_q[opa_q[2:0]] : {{32{a[31]}}, a};
  assign dvs = (b == 32'h00000000) ? 64'h0000000000000001 : {{32{b[31]}}, b};
  assign quo = $signed(dvd) / $signed(dvs);
  assign rem = $signed(dvd) % $signed(dvs);
  assign div0 = ((op == LLEU_OP_DIV) || (op == LLEU_OP_MOD)) && (b == 32'h00000000);
  assign divovf = (op == LLEU_OP_DIV) && !div0 &&
                  !((&quo[63:31]) || !(|quo[63:31]));
  // Wide registers are kept to multiply results and dividends
  assign rejected = ((dest == LLEU_D_WIDE) && (op != LLEU_OP_MUL)) ||
                    (dwide && (op != LLEU_OP_DIV) && (op != LLEU_OP_MOD)) ||
                    ((dest == LLEU_D_GP) && ({1'b0, idx} >= `LLEU_GP_COUNT));
  assign is_imm = (op <= LLEU_OP_MOVE);

  always_comb begin
    case (op)
      LLEU_OP_ADD: imm = {{32{sum33[31]}}, sum33[31:0]};
      LLEU_OP_SUB: imm = {{32{dif33[31]}}, dif33[31:0]};
      LLEU_OP_ABS: imm = a[31] ? {{32{1'b0}}, 32'h00000000 - a} : {32'h00000000, a};
      LLEU_OP_AND: imm = {{32{a[31] & b[31]}}, a & b};
      LLEU_OP_OR: imm = {{32{a[31] | b[31]}}, a | b};
      LLEU_OP_XOR: imm = {{32{a[31] ^ b[31]}}, a ^ b};
      LLEU_OP_MUL: imm = prod;
      LLEU_OP_DIV: imm = {{32{quo[31]}}, quo[31:0]};
      LLEU_OP_MOD: imm = {{32{rem[31]}}, rem[31:0]};
      default: imm = {{32{a[31]}}, a};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer: immediate ops finish at once, register and table loads take longer
  assign issue = (state_q == LLEU_S_TBL) && (tleft_q != 3'd0);
  assign bsel = 2'(tbytes - tleft_q);
  assign tbl_word = tasm_q | (32'(tbl_rdata) << {tgot_q, 3'b000});
  assign tbl_done = rdpend_q && ({1'b0, tgot_q} == 3'(tbytes - 3'd1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= LLEU_S_IDLE;
    end else begin
      case (state_q)
        LLEU_S_IDLE: begin
          if (go_q && exec_ok && !rejected) begin
            if (op == LLEU_OP_LDGP) state_q <= LLEU_S_GPRD;
            if ((op == LLEU_OP_TBLRD) || (op == LLEU_OP_TBLWR)) state_q <= LLEU_S_TBL;
          end
        end
        LLEU_S_GPRD: state_q <= LLEU_S_IDLE;
        LLEU_S_TBL: begin
          if (tbl_done || (issue && (op == LLEU_OP_TBLWR) && (tleft_q == 3'd1))) begin
            state_q <= LLEU_S_IDLE;
          end
        end
        default: state_q <= LLEU_S_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tleft_q <= 3'd0;
      tgot_q <= 2'd0;
      rdpend_q <= 1'b0;
      tasm_q <= 32'h00000000;
    end else begin
      rdpend_q <= issue && (op == LLEU_OP_TBLRD);
      if ((state_q == LLEU_S_IDLE) && go_q) begin
        tleft_q <= tbytes;
        tgot_q <= 2'd0;
        tasm_q <= 32'h00000000;
      end else begin
        if (issue) tleft_q <= tleft_q - 3'd1;
        if (rdpend_q) begin
          tasm_q <= tbl_word;
          tgot_q <= tgot_q + 2'd1;
        end
      end
    end
  end

  always_comb begin
    commit = 1'b0;
    cval = 64'h0000000000000000;
    if ((state_q == LLEU_S_IDLE) && go_q && exec_ok && !rejected && is_imm &&
        !div0 && !divovf) begin
      commit = 1'b1;
      cval = imm;
    end else if (state_q == LLEU_S_GPRD) begin
      commit = 1'b1;
      cval = {{32{gp_rdata[31]}}, gp_rdata};
    end else if ((state_q == LLEU_S_TBL) && tbl_done) begin
      commit = 1'b1;
      cval = {{32{1'b0}}, lleu_ext(tbl_word, {tbytes - 3'd1, 3'b111}, ssgn)};
    end
  end
  assign stv = lleu_trunc(cval, dwm1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_q <= 64'h0000000000000000;
    end else if (commit) begin
      res_q <= stv;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data stores keep their contents over a start of execution; only the table pointer is zeroed
  lleu_ram #(.W(32), .D(`LLEU_GP_DEPTH), .AW(8)) u_gp (
    .pclk(pclk),
    .we(commit && (dest == LLEU_D_GP)),
    .waddr(idx),
    .wdata(stv[31:0]),
    .raddr(idx),
    .rdata_q(gp_rdata)
  );

  always_ff @(posedge pclk) begin
    if (commit && (dest == LLEU_D_WIDE)) begin
      wide_q[idx[2:0]] <= cval;
    end
  end

  lleu_ram #(.W(8), .D(`LLEU_TBL_DEPTH), .AW(13)) u_tbl (
    .pclk(pclk),
    .we(issue && (op == LLEU_OP_TBLWR)),
    .waddr(ptr_q),
    .wdata(opa_q[{bsel, 3'b000} +: 8]),
    .raddr(ptr_q),
    .rdata_q(tbl_rdata)
  );

  // One byte per cycle so a straddling access wraps with the pointer itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q <= 13'h0000;
    end else if (start) begin
      ptr_q <= 13'h0000;
    end else if (issue) begin
      ptr_q <= ptr_q + 13'h0001;
    end else if (go_q && exec_ok && (state_q == LLEU_S_IDLE) && (op == LLEU_OP_SETPTR)) begin
      ptr_q <= opa_q[12:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) axis_q[i] <= 32'h00000000;
    end else if (commit && (dest == LLEU_D_AXIS) &&
                 ($signed(stv[31:0]) >= $signed(axlo_q)) &&
                 ($signed(stv[31:0]) <= $signed(axhi_q))) begin
      axis_q[idx[2:0]] <= stv[31:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // System flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_q <= 1'b0;
    end else if (start) begin
      first_q <= 1'b1;
    end else if (sweep_end) begin
      first_q <= 1'b0;
    end
  end

  // Hardware set beats any clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_q <= 1'b0;
      ovf_abs_q <= 1'b0;
    end else if (go_q && exec_ok && !rejected && (state_q == LLEU_S_IDLE) &&
                 (((op == LLEU_OP_ADD) && add_ovf) || ((op == LLEU_OP_SUB) && sub_ovf) ||
                  ((op == LLEU_OP_ABS) && abs_ovf))) begin
      ovf_q <= 1'b1;
      ovf_abs_q <= (op == LLEU_OP_ABS);
    end else if (start || errclr_tgl) begin
      ovf_q <= 1'b0;
    end else if (commit && (dest == LLEU_D_OVF)) begin
      ovf_q <= stv[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halted_q <= 1'b0;
    end else if ((commit && (dest == LLEU_D_HALT) && stv[0]) ||
                 (go_q && exec_ok && !rejected && (state_q == LLEU_S_IDLE) &&
                  (div0 || divovf))) begin
      halted_q <= 1'b1;
    end else if (errclr_tgl) begin
      halted_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reject_q <= 1'b0;
    end else if (go_q && exec_ok && rejected) begin
      reject_q <= 1'b1;
    end else if (errclr_tgl) begin
      reject_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_q <= 16'h0000;
    end else if (commit && (dest == LLEU_D_HALT) && stv[0]) begin
      code_q <= `LLEU_CODE_HALT;
    end else if (go_q && exec_ok && !rejected && (state_q == LLEU_S_IDLE) && divovf) begin
      code_q <= `LLEU_CODE_DIVOVF;
    end else if (go_q && exec_ok && !rejected && (state_q == LLEU_S_IDLE) && div0) begin
      code_q <= `LLEU_CODE_DIV0;
    end else if (commit && (dest == LLEU_D_AXIS) &&
                 (($signed(stv[31:0]) < $signed(axlo_q)) ||
                  ($signed(stv[31:0]) > $signed(axhi_q)))) begin
      code_q <= `LLEU_CODE_AXWARN;
    end else if (sweep_end && ovf_q) begin
      code_q <= ovf_abs_q ? `LLEU_CODE_ABSOVF : `LLEU_CODE_ADDOVF;
    end else if (errclr_tgl) begin
      code_q <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register read-back; unmapped addresses read zero with an error answer
  always_comb begin
    prdata = 32'h00000000;
    pslverr = 1'b0;
    if (rd || wr) begin
      case (paddr)
        `LLEU_A_CTRL: prdata = {29'h0, errclr_q, run_q, enable_q};
        `LLEU_A_OPA: prdata = opa_q;
        `LLEU_A_OPB: prdata = opb_q;
        `LLEU_A_CMD: prdata = cmd_q;
        `LLEU_A_RES_LO: prdata = res_q[31:0];
        `LLEU_A_RES_HI: prdata = res_q[63:32];
        `LLEU_A_STATUS: prdata = {26'h0, running_q, reject_q, halted_q, ovf_q, first_q, busy};
        `LLEU_A_CODE: prdata = {16'h0000, code_q};
        `LLEU_A_PTR: prdata = {19'h00000, ptr_q};
        `LLEU_A_AXLO: prdata = axlo_q;
        `LLEU_A_AXHI: prdata = axhi_q;
        default: begin
          if (paddr >= `LLEU_A_AXIS && paddr <= `LLEU_A_AXIS_END && paddr[1:0] == 2'b00) begin
            prdata = axis_q[paddr[4:2]];
          end else begin
            pslverr = 1'b1;
          end
        end
      endcase
      if (!rd) prdata = 32'h00000000;
    end
  end
endmodule

// ---- verif/lleu_core_props.sv ----
// Checker on the data unit ports: bus answers, halt and status code timing
`include "lleu_map.svh"
module lleu_core_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic fast_stop,
  input wire logic [15:0] status_code
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  logic acc;
  logic any_wr;
  logic cmd_wr;
  logic ctl_wr;
  logic mapped;
  logic [3:0] wr_age_q;
  logic [3:0] cmd_age_q;
  assign acc = psel && penable;
  assign any_wr = acc && pwrite;
  assign cmd_wr = any_wr && paddr == `LLEU_A_CMD;
  assign ctl_wr = any_wr && paddr == `LLEU_A_CTRL;
  assign mapped = paddr[1:0] == 2'h0 && (paddr <= `LLEU_A_AXHI ||
    (paddr >= `LLEU_A_AXIS && paddr <= `LLEU_A_AXIS_END));
  // Ages saturate so a long idle stretch never wraps back into the window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wr_age_q <= 4'hf;
    else if (any_wr) wr_age_q <= 4'h0;
    else if (wr_age_q != 4'hf) wr_age_q <= wr_age_q + 4'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cmd_age_q <= 4'hf;
    else if (cmd_wr) cmd_age_q <= 4'h0;
    else if (cmd_age_q != 4'hf) cmd_age_q <= cmd_age_q + 4'h1;
  end
  sequence halt_rise;
    $rose(fast_stop);
  endsequence
  sequence code_new;
    $changed(status_code);
  endsequence
  ////////////////////////////////////////////////////////////////
  ready_a: assert property (acc |-> pready)
    else $error("access phase without ready");
  rdata_idle_a: assert property (!(acc && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside a read access");
  slverr_map_a: assert property (acc |-> pslverr == !mapped)
    else $error("error response does not match the address map");
  halt_code_a: assert property (halt_rise |-> status_code inside
    {`LLEU_CODE_HALT, `LLEU_CODE_DIV0, `LLEU_CODE_DIVOVF}) else $error("stop without stop code");
  halt_cause_a: assert property (halt_rise |-> cmd_age_q inside {[1:7]})
    else $error("stop not caused by a command");
  halt_hold_a: assert property (fast_stop && !ctl_wr |=> fast_stop)
    else $error("stop released without a control write");
  halt_clear_a: assert property ($fell(fast_stop) |-> $past(ctl_wr))
    else $error("stop cleared without a control write");
  stop_code_a: assert property (fast_stop |-> status_code != 16'h0)
    else $error("stopped with an empty status code");
  code_cause_a: assert property (code_new |-> wr_age_q <= 4'h7)
    else $error("status code changed with no access");
  ovf_code_a: assert property (code_new and status_code inside {`LLEU_CODE_ADDOVF,
    `LLEU_CODE_ABSOVF} |-> $past(ctl_wr)) else $error("overflow code outside sweep end");
  axis_code_a: assert property (code_new and status_code == `LLEU_CODE_AXWARN |->
    cmd_age_q inside {[1:7]}) else $error("axis warning without a command");
endmodule

bind lleu_core lleu_core_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .fast_stop(fast_stop), .status_code(status_code)
);

// ---- verif/lleu_prog_model.sv ----
// Program-side bus model: issues the register accesses of a sweeping program
module lleu_prog_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic err = 1'b0;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
  end
  // An idle edge before each setup: no strobe is driven twice in one time step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input int gap,
                      output logic [31:0] q);
    repeat (gap + 1) @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data flips so a stale value never passes for a held one
    pwdata <= ~d;
  endtask
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench for the logic engine data unit
`include "lleu_map.svh"
module testbench import lleu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] by_wide = 32'h10000000;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, fast_stop;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [15:0] status_code;
  logic [31:0] ctl = 32'h0;
  int miscompares = 0;
  int comparisons = 0;
  always #5 pclk = ~pclk;
  lleu_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fast_stop(fast_stop), .status_code(status_code));
  lleu_prog_model u_prog (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    u_prog.xfer(1'b1, a, d, 0, x);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    u_prog.xfer(1'b0, a, 32'h0, 0, x);
    chk(nm, x, e);
  endtask
  task automatic cs(input logic [31:0] c);
    ctl = c;
    wr(`LLEU_A_CTRL, c);
  endtask
  task automatic sweep;
    wr(`LLEU_A_CTRL, ctl | 32'h10);
  endtask
  task automatic clr;
    cs(ctl ^ 32'h4);
  endtask
  function automatic logic [31:0] cw(lleu_op_t o, logic [7:0] ix, lleu_dest_t ds,
      logic [1:0] tz = 2'h0, logic sg = 1'b1, logic [5:0] dw = 6'h1f, logic [5:0] sw = 6'h1f);
    logic [31:0] c;
    c = 32'h0;
    c[`LLEU_F_OP] = o;
    c[`LLEU_F_IDX] = ix;
    c[`LLEU_F_SWM1] = sw;
    c[`LLEU_F_SSGN] = sg;
    c[`LLEU_F_DWM1] = dw;
    c[`LLEU_F_DEST] = ds;
    c[`LLEU_F_TSZ] = tz;
    return c;
  endfunction
  // Busy is polled with idle gaps between reads
  task automatic op(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
    logic [31:0] s;
    wr(`LLEU_A_OPA, a);
    wr(`LLEU_A_OPB, b);
    wr(`LLEU_A_CMD, c);
    s = 32'h1;
    while (s[0] !== 1'b0) u_prog.xfer(1'b0, `LLEU_A_STATUS, 32'h0, 2, s);
  endtask
  task automatic ar(input string nm, input lleu_op_t o, input logic [31:0] a, input logic [31:0] b,
      input logic [5:0] sw, input logic sg, input logic [5:0] dw, input logic [31:0] e);
    op(a, b, cw(o, 8'h1, LLEU_D_GP, 2'h0, sg, dw, sw));
    rc(nm, `LLEU_A_RES_LO, e);
  endtask
  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rc("ctrl", `LLEU_A_CTRL, 32'h0);
    rc("axlo", `LLEU_A_AXLO, `LLEU_AXLO_RST);
    rc("axhi", `LLEU_A_AXHI, `LLEU_AXHI_RST);
    rc("status", `LLEU_A_STATUS, 32'h0);
    u_prog.xfer(1'b0, 8'h30, 32'h0, 0, v);
    chk("hole", 32'(u_prog.err), 32'h1);
    done("reset");
    cs(32'h3);
    rc("first", `LLEU_A_STATUS, 32'h22);
    sweep;
    rc("later", `LLEU_A_STATUS, 32'h20);
    ar("add", LLEU_OP_ADD, 32'h7, 32'h5, 6'h1f, 1'b1, 6'h1f, 32'hc);
    ar("sub", LLEU_OP_SUB, 32'h3, 32'h5, 6'h1f, 1'b1, 6'h1f, 32'hfffffffe);
    ar("abs", LLEU_OP_ABS, 32'hfffffff7, 32'h0, 6'h1f, 1'b1, 6'h1f, 32'h9);
    ar("and", LLEU_OP_AND, 32'hf0f0, 32'hff00, 6'h1f, 1'b1, 6'h1f, 32'hf000);
    ar("or", LLEU_OP_OR, 32'hf0f0, 32'hff00, 6'h1f, 1'b1, 6'h1f, 32'hfff0);
    ar("xor", LLEU_OP_XOR, 32'hf0f0, 32'hff00, 6'h1f, 1'b1, 6'h1f, 32'h0ff0);
    ar("div", LLEU_OP_DIV, 32'h64, 32'h7, 6'h1f, 1'b1, 6'h1f, 32'he);
    ar("mod", LLEU_OP_MOD, 32'h64, 32'h7, 6'h1f, 1'b1, 6'h1f, 32'h2);
    ar("sext", LLEU_OP_ADD, 32'h80, 32'h0, 6'h7, 1'b1, 6'h1f, 32'hffffff80);
    ar("zext", LLEU_OP_ADD, 32'h80, 32'h0, 6'h7, 1'b0, 6'h1f, 32'h80);
    ar("bitsrc", LLEU_OP_ADD, 32'h1, 32'h0, 6'h0, 1'b1, 6'h1f, 32'h1);
    ar("trunc", LLEU_OP_ADD, 32'h12345678, 32'h0, 6'h1f, 1'b1, 6'hf, 32'h5678);
    ar("bitdst", LLEU_OP_ADD, 32'h3, 32'h0, 6'h1f, 1'b1, 6'h0, 32'h1);
    ar("move", LLEU_OP_MOVE, 32'h5a, 32'h0, 6'h1f, 1'b1, 6'h1f, 32'h5a);
    done("arith");
    op(32'h7fffffff, 32'h1, cw(LLEU_OP_ADD, 8'h0, LLEU_D_NONE));
    rc("ovf", `LLEU_A_STATUS, 32'h24);
    sweep;
    rc("c95", `LLEU_A_CODE, 32'h95);
    clr;
    rc("ovfclr", `LLEU_A_STATUS, 32'h20);
    rc("codeclr", `LLEU_A_CODE, 32'h0);
    op(32'h80000000, 32'h0, cw(LLEU_OP_ABS, 8'h0, LLEU_D_NONE));
    op(32'h0, 32'h0, cw(LLEU_OP_MOVE, 8'h0, LLEU_D_OVF, 2'h0, 1'b1, 6'h0));
    sweep;
    rc("quiet", `LLEU_A_CODE, 32'h0);
    op(32'h80000000, 32'h0, cw(LLEU_OP_ABS, 8'h0, LLEU_D_NONE));
    sweep;
    rc("c96", `LLEU_A_CODE, 32'h96);
    clr;
    done("overflow");
    op(32'h10000, 32'h10000, cw(LLEU_OP_MUL, 8'h7, LLEU_D_WIDE, 2'h0, 1'b1, 6'h3f));
    rc("mulhi", `LLEU_A_RES_HI, 32'h1);
    rc("mullo", `LLEU_A_RES_LO, 32'h0);
    op(32'h7, 32'h100, cw(LLEU_OP_DIV, 8'h2, LLEU_D_GP) | by_wide);
    rc("wdiv", `LLEU_A_RES_LO, 32'h1000000);
    op(32'h7, 32'h3, cw(LLEU_OP_MOD, 8'h2, LLEU_D_GP) | by_wide);
    rc("wmod", `LLEU_A_RES_LO, 32'h1);
    op(32'h1, 32'h1, cw(LLEU_OP_ADD, 8'h0, LLEU_D_WIDE));
    rc("rejw", `LLEU_A_STATUS, 32'h30);
    clr;
    op(32'h1, 32'h1, cw(LLEU_OP_ADD, 8'hff, LLEU_D_GP));
    rc("rejgp", `LLEU_A_STATUS, 32'h30);
    clr;
    done("wide");
    op(32'h1ffe, 32'h0, cw(LLEU_OP_SETPTR, 8'h0, LLEU_D_NONE));
    op(32'h11223344, 32'h0, cw(LLEU_OP_TBLWR, 8'h0, LLEU_D_NONE, 2'h2));
    rc("ptrwrap", `LLEU_A_PTR, 32'h2);
    op(32'h80, 32'h0, cw(LLEU_OP_TBLWR, 8'h0, LLEU_D_NONE, 2'h0));
    op(32'h8001, 32'h0, cw(LLEU_OP_TBLWR, 8'h0, LLEU_D_NONE, 2'h1));
    rc("ptr5", `LLEU_A_PTR, 32'h5);
    op(32'h1ffe, 32'h0, cw(LLEU_OP_SETPTR, 8'h0, LLEU_D_NONE));
    op(32'h0, 32'h0, cw(LLEU_OP_TBLRD, 8'h0, LLEU_D_NONE, 2'h2));
    rc("tword", `LLEU_A_RES_LO, 32'h11223344);
    op(32'h0, 32'h0, cw(LLEU_OP_TBLRD, 8'h0, LLEU_D_NONE, 2'h0));
    rc("sbyte", `LLEU_A_RES_LO, 32'hffffff80);
    op(32'h0, 32'h0, cw(LLEU_OP_TBLRD, 8'h0, LLEU_D_NONE, 2'h1, 1'b0));
    rc("uhalf", `LLEU_A_RES_LO, 32'h8001);
    rc("ptrend", `LLEU_A_PTR, 32'h5);
    done("table");
    op(32'h5, 32'h0, cw(LLEU_OP_MOVE, 8'h0, LLEU_D_AXIS));
    rc("axis", `LLEU_A_AXIS, 32'h5);
    op(32'h10000, 32'h0, cw(LLEU_OP_MOVE, 8'h0, LLEU_D_AXIS));
    rc("axkeep", `LLEU_A_AXIS, 32'h5);
    rc("axcode", `LLEU_A_CODE, 32'ha0);
    clr;
    done("axis");
    op(32'h7, 32'h1, cw(LLEU_OP_DIV, 8'h2, LLEU_D_GP) | by_wide);
    chk("divstop", 32'(fast_stop), 32'h1);
    rc("c94", `LLEU_A_CODE, 32'h94);
    clr;
    @(posedge pclk);
    chk("resume", 32'(fast_stop), 32'h0);
    op(32'h7, 32'h0, cw(LLEU_OP_DIV, 8'h2, LLEU_D_GP));
    chk("div0", 32'(status_code), 32'h93);
    clr;
    op(32'h1, 32'h0, cw(LLEU_OP_MOVE, 8'h0, LLEU_D_HALT, 2'h0, 1'b0, 6'h0, 6'h0));
    chk("halt", 32'(fast_stop), 32'h1);
    rc("c91", `LLEU_A_CODE, 32'h91);
    clr;
    done("halt");
    op(32'h80000000, 32'h0, cw(LLEU_OP_ABS, 8'h0, LLEU_D_NONE));
    cs(ctl & 32'hfffffffc);
    cs(ctl | 32'h3);
    rc("restart", `LLEU_A_STATUS, 32'h22);
    rc("ptr0", `LLEU_A_PTR, 32'h0);
    op(32'h0, 32'h0, cw(LLEU_OP_LDGP, 8'h1, LLEU_D_NONE));
    rc("kept", `LLEU_A_RES_LO, 32'h5a);
    done("restart");
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    print_verdict;
  end
endmodule
